// ===== include/eeprm_pkg.sv
package eeprm_pkg;

  localparam int          EEPRM_ADDR_W      = 11;
  localparam int          EEPRM_DEPTH       = 2048;
  localparam int          EEPRM_PAGE_W      = 5;
  localparam logic [7:0]  EEPRM_ERASED      = 8'h0_0FF;

  localparam logic [7:0]  CMD_ARM_WRITE     = 8'h0_006;
  localparam logic [7:0]  CMD_DISARM_WRITE  = 8'h0_004;
  localparam logic [7:0]  CMD_STATUS_READ   = 8'h0_005;
  localparam logic [7:0]  CMD_STATUS_WRITE  = 8'h0_001;
  localparam logic [7:0]  CMD_MEM_READ      = 8'h0_003;
  localparam logic [7:0]  CMD_MEM_WRITE     = 8'h0_002;

  localparam int          SR_LOCK_BIT       = 7;
  localparam int          SR_GUARD_HI_BIT   = 3;
  localparam int          SR_GUARD_LO_BIT   = 2;
  localparam int          SR_ARM_BIT        = 1;
  localparam int          SR_BUSY_BIT       = 0;
  localparam logic [7:0]  SR_WRITABLE_MASK  = 8'h0_08C;

  localparam logic [5:0]  BIT_CNT_INSTR_END = 6'd8;
  localparam logic [5:0]  BIT_CNT_ADDR_END  = 6'd24;

  localparam real         WRITE_TIME_MS     = 5.0;
  localparam real         SYS_CLK_MHZ       = 100.0;
  localparam int          WRITE_CYCLES      = int'(WRITE_TIME_MS * SYS_CLK_MHZ * 1000.0);

  localparam int          FIFO_WIDTH        = 8;
  localparam int          FIFO_DEPTH        = 4;

  typedef struct packed {
    logic [EEPRM_ADDR_W-1:0] addr;
    logic [7:0]              data;
  } eeprm_wr_t;

  typedef enum logic [5:0] {
    ST_IDLE   = 6'b00_0001,
    ST_INSTR  = 6'b00_0010,
    ST_ADDR   = 6'b00_0100,
    ST_DATA   = 6'b00_1000,
    ST_IGNORE = 6'b01_0000,
    ST_COMMIT = 6'b10_0000
  } eeprm_state_t;

endpackage

// ===== src/eeprm_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module eeprm_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic             i_sys_clk,
  input  wire logic             i_rst_n,
  input  wire logic             i_clr,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic      [WIDTH-1:0] o_out_data
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PW:0]      wr_reg;
  logic [PW:0]      rd_reg;
  logic             push;
  logic             pop;

  assign o_in_ready  = (wr_reg - rd_reg) != (PW+1)'(DEPTH);
  assign o_out_valid = wr_reg != rd_reg;
  assign o_out_data  = mem_reg[rd_reg[PW-1:0]];
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;

  always_ff @(posedge i_sys_clk) begin
    if (push) begin
      mem_reg[wr_reg[PW-1:0]] <= i_in_data;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_reg <= '0;
      rd_reg <= '0;
    end else if (i_clr) begin
      wr_reg <= '0;
      rd_reg <= '0;
    end else begin
      if (push) begin
        wr_reg <= wr_reg + 1'b1;
      end
      if (pop) begin
        rd_reg <= rd_reg + 1'b1;
      end
    end
  end
endmodule // eeprm_fifo
`default_nettype wire

// ===== src/eeprm_spi_eeprom.sv
`timescale 1ns/1ps
`default_nettype none
module eeprm_spi_eeprom
  import eeprm_pkg::*;
#(
  parameter int WRITE_CYC = WRITE_CYCLES
) (
  input  wire logic i_sys_clk,
  input  wire logic i_rst_n,
  input  wire logic i_sel_n,
  input  wire logic i_sclk,
  input  wire logic i_sdi,
  input  wire logic i_guard_n,
  input  wire logic i_pause_n,
  output logic      o_sdo,
  output logic      o_sdo_oe,
  output logic      o_active
);
  logic [1:0]              sel_sync_reg;
  logic [1:0]              sclk_sync_reg;
  logic [1:0]              sdi_sync_reg;
  logic [1:0]              guard_sync_reg;
  logic [1:0]              pause_sync_reg;
  logic                    sclk_prev_reg;
  logic                    sel_n;
  logic                    paused;
  logic                    rise;
  logic                    fall;
  eeprm_state_t            state_reg;
  logic [7:0]              instr_reg;
  logic [7:0]              shift_reg;
  logic [5:0]              bit_cnt_reg;
  logic [15:0]             addr_sh_reg;
  logic [EEPRM_ADDR_W-1:0] addr_reg;
  logic [7:0]              out_reg;
  logic [2:0]              out_idx_reg;
  logic                    out_en_reg;
  logic                    lock_reg;
  logic [1:0]              guard_reg;
  logic                    arm_reg;
  logic                    busy_reg;
  logic [31:0]             wcnt_reg;
  logic [7:0]              sr_new_reg;
  logic                    sr_pend_reg;
  logic                    mem_pend_reg;
  logic [7:0]              mem [EEPRM_DEPTH];
  logic [7:0]              status;
  logic                    hw_lock;
  logic [7:0]              next_byte;
  logic                    byte_done;
  logic                    fifo_in_valid;
  logic                    fifo_in_ready;
  logic                    fifo_out_valid;
  logic                    fifo_out_ready;
  logic [FIFO_WIDTH+EEPRM_ADDR_W-1:0] fifo_out_data;
  eeprm_wr_t               fifo_in;
  eeprm_wr_t               fifo_out;
  logic                    deselect_edge;
  logic                    sel_prev_reg;

  function automatic logic addr_guarded(input logic [1:0] g, input logic [EEPRM_ADDR_W-1:0] a);
    unique case (g)
      2'b00:   addr_guarded = 1'b0;
      2'b01:   addr_guarded = a[10] & a[9];
      2'b10:   addr_guarded = a[10];
      default: addr_guarded = 1'b1;
    endcase
  endfunction

  assign sel_n     = sel_sync_reg[1];
  assign paused    = !pause_sync_reg[1] && !sel_n;
  assign rise      = sclk_sync_reg[1] && !sclk_prev_reg && !sel_n && !paused;
  assign fall      = !sclk_sync_reg[1] && sclk_prev_reg && !sel_n && !paused;
  assign hw_lock   = lock_reg && !guard_sync_reg[1];
  assign status    = {lock_reg, 3'b000, guard_reg, arm_reg, busy_reg};
  assign next_byte = {shift_reg[6:0], sdi_sync_reg[1]};
  assign byte_done = rise && (bit_cnt_reg[2:0] == 3'd7);
  assign deselect_edge = sel_n && !sel_prev_reg;
  assign fifo_out  = eeprm_wr_t'(fifo_out_data);
  assign fifo_out_ready = state_reg == ST_COMMIT;

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sel_sync_reg   <= 2'b11;
      sclk_sync_reg  <= 2'b00;
      sdi_sync_reg   <= 2'b00;
      guard_sync_reg <= 2'b11;
      pause_sync_reg <= 2'b11;
      sclk_prev_reg  <= 1'b0;
      sel_prev_reg   <= 1'b1;
    end else begin
      sel_sync_reg   <= {sel_sync_reg[0], i_sel_n};
      sclk_sync_reg  <= {sclk_sync_reg[0], i_sclk};
      sdi_sync_reg   <= {sdi_sync_reg[0], i_sdi};
      guard_sync_reg <= {guard_sync_reg[0], i_guard_n};
      pause_sync_reg <= {pause_sync_reg[0], i_pause_n};
      sclk_prev_reg  <= sclk_sync_reg[1];
      sel_prev_reg   <= sel_sync_reg[1];
    end
  end

  // serial frame decoder
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg   <= ST_IDLE;
      instr_reg   <= '0;
      shift_reg   <= '0;
      bit_cnt_reg <= '0;
      addr_sh_reg <= '0;
      addr_reg    <= '0;
    end else if (sel_n) begin
      if (state_reg == ST_DATA && instr_reg == CMD_MEM_WRITE && mem_pend_reg
          && bit_cnt_reg[2:0] == 3'd0) begin
        state_reg <= ST_COMMIT;
      end else if (state_reg != ST_COMMIT || !fifo_out_valid) begin
        state_reg <= ST_IDLE;
      end
      bit_cnt_reg <= '0;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          state_reg <= ST_INSTR;
        end
        ST_INSTR: begin
          if (rise) begin
            shift_reg   <= next_byte;
            bit_cnt_reg <= bit_cnt_reg + 6'd1;
            if (byte_done) begin
              instr_reg <= next_byte;
              unique case (next_byte)
                CMD_ARM_WRITE, CMD_DISARM_WRITE, CMD_STATUS_READ: state_reg <= ST_DATA;
                CMD_STATUS_WRITE: state_reg <= (arm_reg && !busy_reg && !hw_lock)
                                               ? ST_DATA : ST_IGNORE;
                CMD_MEM_READ: state_reg <= busy_reg ? ST_IGNORE : ST_ADDR;
                CMD_MEM_WRITE: state_reg <= (arm_reg && !busy_reg) ? ST_ADDR : ST_IGNORE;
                default: state_reg <= ST_IGNORE;
              endcase
            end
          end
        end
        ST_ADDR: begin
          if (rise) begin
            addr_sh_reg <= {addr_sh_reg[14:0], sdi_sync_reg[1]};
            bit_cnt_reg <= bit_cnt_reg + 6'd1;
            if (bit_cnt_reg == BIT_CNT_ADDR_END - 6'd1) begin
              addr_reg  <= {addr_sh_reg[9:0], sdi_sync_reg[1]};
              state_reg <= ST_DATA;
            end
          end
        end
        ST_DATA: begin
          if (rise) begin
            shift_reg   <= next_byte;
            bit_cnt_reg <= (bit_cnt_reg == 6'd63) ? 6'd32 : bit_cnt_reg + 6'd1;
            if (byte_done && instr_reg == CMD_MEM_READ) begin
              addr_reg <= addr_reg + 11'd1;
            end
            if (byte_done && instr_reg == CMD_MEM_WRITE) begin
              addr_reg <= {addr_reg[10:5], addr_reg[4:0] + 5'd1};
            end
          end
        end
        ST_IGNORE: begin
          bit_cnt_reg <= '0;
        end
        ST_COMMIT: begin
          if (!fifo_out_valid) begin
            state_reg <= ST_IDLE;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // page buffer feed: bytes past the first four of a frame are dropped
  assign fifo_in.addr  = addr_reg;
  assign fifo_in.data  = next_byte;
  assign fifo_in_valid = state_reg == ST_DATA && instr_reg == CMD_MEM_WRITE && byte_done
                         && fifo_in_ready;

  eeprm_fifo #(
    .WIDTH (FIFO_WIDTH + EEPRM_ADDR_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .i_sys_clk   (i_sys_clk),
    .i_rst_n     (i_rst_n),
    .i_clr       (state_reg == ST_IDLE && !sel_n),
    .i_in_valid  (fifo_in_valid),
    .o_in_ready  (fifo_in_ready),
    .i_in_data   (fifo_in),
    .o_out_valid (fifo_out_valid),
    .i_out_ready (fifo_out_ready),
    .o_out_data  (fifo_out_data)
  );

  // memory array, erased state at start
  initial begin
    for (int i = 0; i < EEPRM_DEPTH; i++) begin
      mem[i] = EEPRM_ERASED;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (state_reg == ST_COMMIT && fifo_out_valid
        && !addr_guarded(guard_reg, fifo_out.addr)) begin
      mem[fifo_out.addr] <= fifo_out.data;
    end
  end

  // status bits, write timer and arm latch
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      lock_reg     <= 1'b0;
      guard_reg    <= 2'b00;
      arm_reg      <= 1'b0;
      busy_reg     <= 1'b0;
      wcnt_reg     <= '0;
      sr_new_reg   <= '0;
      sr_pend_reg  <= 1'b0;
      mem_pend_reg <= 1'b0;
    end else begin
      if (state_reg == ST_DATA && instr_reg == CMD_STATUS_WRITE && byte_done
          && bit_cnt_reg == 6'd15) begin
        sr_new_reg  <= next_byte & SR_WRITABLE_MASK;
        sr_pend_reg <= 1'b1;
      end
      if (state_reg == ST_DATA && instr_reg == CMD_MEM_WRITE && byte_done) begin
        mem_pend_reg <= 1'b1;
      end
      if (deselect_edge) begin
        sr_pend_reg  <= sr_pend_reg && (busy_reg || (bit_cnt_reg == 6'd16 && !hw_lock));
        mem_pend_reg <= 1'b0;
        if ((instr_reg == CMD_ARM_WRITE || instr_reg == CMD_DISARM_WRITE)
            && bit_cnt_reg == BIT_CNT_INSTR_END && state_reg == ST_DATA) begin
          arm_reg <= instr_reg == CMD_ARM_WRITE;
        end
        if (!busy_reg && ((sr_pend_reg && bit_cnt_reg == 6'd16 && !hw_lock)
            || (mem_pend_reg && bit_cnt_reg[2:0] == 3'd0))) begin
          busy_reg <= 1'b1;
          wcnt_reg <= '0;
        end
      end else if (busy_reg) begin
        if (wcnt_reg == 32'(WRITE_CYC - 1)) begin
          busy_reg    <= 1'b0;
          arm_reg     <= 1'b0;
          sr_pend_reg <= 1'b0;
          if (sr_pend_reg) begin
            lock_reg  <= sr_new_reg[SR_LOCK_BIT];
            guard_reg <= {sr_new_reg[SR_GUARD_HI_BIT], sr_new_reg[SR_GUARD_LO_BIT]};
          end
        end else begin
          wcnt_reg <= wcnt_reg + 32'd1;
        end
      end
    end
  end

  // output shifter, updated on falling serial clock
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      out_reg     <= '0;
      out_idx_reg <= '0;
      out_en_reg  <= 1'b0;
    end else if (sel_n || state_reg != ST_DATA) begin
      out_en_reg  <= 1'b0;
      out_idx_reg <= '0;
    end else if (fall && bit_cnt_reg[2:0] == 3'd0) begin
      out_idx_reg <= 3'd6;
      if (instr_reg == CMD_STATUS_READ) begin
        out_reg    <= status;
        out_en_reg <= 1'b1;
      end else if (instr_reg == CMD_MEM_READ) begin
        out_reg    <= mem[addr_reg];
        out_en_reg <= 1'b1;
      end
    end else if (fall) begin
      out_idx_reg <= out_idx_reg - 3'd1;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_sdo    <= 1'b0;
      o_sdo_oe <= 1'b0;
      o_active <= 1'b0;
    end else begin
      o_sdo    <= (fall && bit_cnt_reg[2:0] == 3'd0)
                  ? (instr_reg == CMD_STATUS_READ ? status[7] : mem[addr_reg][7])
                  : (fall ? out_reg[out_idx_reg] : o_sdo);
      o_sdo_oe <= out_en_reg && !paused && !sel_n;
      o_active <= !sel_n || busy_reg;
    end
  end
endmodule // eeprm_spi_eeprom
`default_nettype wire

// ===== verification/eeprm_spi_props.sv
`timescale 1ns/1ps
`default_nettype none
module eeprm_spi_props #(
  parameter int WRITE_CYC = 50
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_sel_n,
  input wire logic i_sclk,
  input wire logic i_sdi,
  input wire logic i_guard_n,
  input wire logic i_pause_n,
  input wire logic o_sdo,
  input wire logic o_sdo_oe,
  input wire logic o_active
);
  localparam int IDLE_LIM = WRITE_CYC + 200;
  int sel_hi_cnt;

  // cycles spent deselected, saturating past the longest internal write
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sel_hi_cnt <= 0;
    end else if (!i_sel_n) begin
      sel_hi_cnt <= 0;
    end else if (sel_hi_cnt < IDLE_LIM) begin
      sel_hi_cnt <= sel_hi_cnt + 1;
    end
  end

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);

  a_desel_float: assert property (i_sel_n [*6] |-> !o_sdo_oe)
    else $error("output driven while deselected");
  a_pause_float: assert property ((!i_pause_n) [*6] |-> !o_sdo_oe)
    else $error("output driven while paused");
  a_sdo_on_fall: assert property ((i_sclk && i_pause_n && !i_sel_n) [*5] |-> $stable(o_sdo))
    else $error("output changed while serial clock high");
  a_active_sel: assert property ((!i_sel_n) [*6] |-> o_active)
    else $error("not active while selected");
  a_sel_wakes: assert property ($fell(i_sel_n) |-> ##[1:6] o_active)
    else $error("select did not wake device");
  a_standby_idle: assert property (sel_hi_cnt == IDLE_LIM |-> !o_active)
    else $error("active long after deselect");
  a_oe_needs_sel: assert property ($rose(o_sdo_oe) |-> !i_sel_n && i_pause_n)
    else $error("output enabled without select");
  a_reset_quiet: assert property ($rose(i_rst_n) |-> !o_sdo_oe && !o_active)
    else $error("outputs not idle after reset");

  c_read_out: cover property ($rose(o_sdo_oe));
  c_paused: cover property (!i_pause_n && !i_sel_n);
  c_write_busy: cover property (o_active && sel_hi_cnt == 20);
endmodule // eeprm_spi_props

bind eeprm_spi_eeprom eeprm_spi_props #(.WRITE_CYC(WRITE_CYC)) eeprm_spi_props_i (
  .i_sys_clk (i_sys_clk),
  .i_rst_n   (i_rst_n),
  .i_sel_n   (i_sel_n),
  .i_sclk    (i_sclk),
  .i_sdi     (i_sdi),
  .i_guard_n (i_guard_n),
  .i_pause_n (i_pause_n),
  .o_sdo     (o_sdo),
  .o_sdo_oe  (o_sdo_oe),
  .o_active  (o_active)
);
`default_nettype wire

// ===== verification/eeprm_host.sv
`timescale 1ns/1ps
`default_nettype none
module eeprm_host (
  input  wire logic i_sys_clk,
  input  wire logic i_sdo,
  output logic      o_sel_n,
  output logic      o_sclk,
  output logic      o_sdi,
  output logic      o_pause_n
);
  initial begin
    o_sel_n   = 1'b1;
    o_sclk    = 1'b0;
    o_sdi     = 1'b0;
    o_pause_n = 1'b1;
  end

  // one frame of n clocks, msb first, clock rests low outside frames
  task automatic xfer(input logic [47:0] tx, input int n, input int pz,
                      output logic [47:0] rx);
    rx = '0;
    @(posedge i_sys_clk);
    #1 o_sel_n = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      o_sdi = tx[i];
      #62.5 o_sclk = 1'b1;
      rx = {rx[46:0], i_sdo};
      #62.5 o_sclk = 1'b0;
      if (i == pz) begin
        // pause with junk clocks and data the device must ignore
        #50 o_pause_n = 1'b0;
        #100;
        repeat (3) begin
          o_sdi = ~o_sdi;
          #62.5 o_sclk = 1'b1;
          #62.5 o_sclk = 1'b0;
        end
        #100 o_pause_n = 1'b1;
        #100;
      end
    end
    #100 o_sel_n = 1'b1;
    o_sdi = ~o_sdi;
    #200;
  endtask
endmodule // eeprm_host
`default_nettype wire

// ===== verification/spi_eeprom_command_status_test.sv
`timescale 1ns/1ps
`default_nettype none
module spi_eeprom_command_status_test;
  import eeprm_pkg::*;
  logic        clk;
  logic        rst_n;
  logic        guard_n;
  logic        sel_n;
  logic        sclk;
  logic        sdi;
  logic        pause_n;
  logic        sdo;
  logic        sdo_oe;
  logic        active;
  int          miscompares;
  int          checks_done;
  logic [47:0] rx;
  logic [7:0]  s;
  logic [15:0] d;

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  eeprm_spi_eeprom #(.WRITE_CYC(400)) eeprm_spi_eeprom_i (
    .i_sys_clk (clk),
    .i_rst_n   (rst_n),
    .i_sel_n   (sel_n),
    .i_sclk    (sclk),
    .i_sdi     (sdi),
    .i_guard_n (guard_n),
    .i_pause_n (pause_n),
    .o_sdo     (sdo),
    .o_sdo_oe  (sdo_oe),
    .o_active  (active)
  );

  // a floating output is seen as the inverse of its last level
  eeprm_host eeprm_host_i (
    .i_sys_clk (clk),
    .i_sdo     (sdo_oe ? sdo : ~sdo),
    .o_sel_n   (sel_n),
    .o_sclk    (sclk),
    .o_sdi     (sdi),
    .o_pause_n (pause_n)
  );

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", nm, e, g);
      miscompares++;
    end
  endtask

  task automatic send(input logic [47:0] tx, input int n);
    logic [47:0] r;
    eeprm_host_i.xfer(tx, n, -1, r);
  endtask

  task automatic rd_status(output logic [7:0] v);
    logic [47:0] r;
    eeprm_host_i.xfer(48'({CMD_STATUS_READ, 8'h00}), 16, -1, r);
    v = r[7:0];
  endtask

  task automatic rd_mem(input logic [15:0] a, output logic [15:0] v);
    logic [47:0] r;
    eeprm_host_i.xfer(48'({CMD_MEM_READ, a, 16'h0000}), 40, -1, r);
    v = r[15:0];
  endtask

  task automatic wait_idle();
    logic [7:0] v;
    rd_status(v);
    repeat (20) if (v[0] !== 1'b0) rd_status(v);
    chk("busy_flag", 8'h00, {7'h00, v[0]});
  endtask

  task automatic arm();
    send(48'(CMD_ARM_WRITE), 8);
  endtask

  task automatic finish_test();
    $display("checks_done %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    rst_n       = 1'b0;
    guard_n     = 1'b1;
    miscompares = 0;
    checks_done = 0;
    repeat (20) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (10) @(posedge clk);
    rd_status(s);
    chk("status_reset", 8'h00, s);
    rd_mem(16'h07FF, d);
    chk("erased_top", 8'hFF, d[15:8]);
    chk("read_wrap", 8'hFF, d[7:0]);
    send(48'({CMD_MEM_WRITE, 16'h0010, 8'h5A}), 32);
    rd_mem(16'h0010, d);
    chk("unarmed_write", 8'hFF, d[15:8]);
    send(48'({CMD_ARM_WRITE, 1'b0}), 9);
    rd_status(s);
    chk("arm_9_clocks", 8'h00, s);
    arm();
    rd_status(s);
    chk("arm_set", 8'h02, s);
    send(48'(CMD_DISARM_WRITE), 8);
    rd_status(s);
    chk("disarm", 8'h00, s);
    send(48'({8'h07, CMD_ARM_WRITE}), 16);
    rd_status(s);
    chk("unknown_code", 8'h00, s);
    arm();
    send(48'({CMD_MEM_WRITE, 16'hF810, 8'h5A}), 32);
    chk("active_busy", 8'h01, {7'h00, active});
    rd_status(s);
    chk("write_busy", 8'h03, s);
    wait_idle();
    rd_status(s);
    chk("arm_after_write", 8'h00, s);
    repeat (650) @(posedge clk);
    #1 chk("standby", 8'h00, {7'h00, active});
    rd_mem(16'h0010, d);
    chk("high_addr_ignored", 8'h5A, d[15:8]);
    arm();
    send(48'({CMD_MEM_WRITE, 16'h003E, 24'h11_2233}), 48);
    wait_idle();
    rd_mem(16'h003E, d);
    chk("page_first", 8'h11, d[15:8]);
    chk("read_next", 8'h22, d[7:0]);
    rd_mem(16'h0020, d);
    chk("page_wrap", 8'h33, d[15:8]);
    arm();
    send(48'({CMD_STATUS_WRITE, 8'hFF}), 16);
    rd_status(s);
    chk("status_write_busy", 8'h03, s);
    wait_idle();
    eeprm_host_i.xfer(48'({CMD_STATUS_READ, 16'h0000}), 24, 12, rx);
    chk("status_paused", 8'h8C, rx[15:8]);
    chk("status_repeat", 8'h8C, rx[7:0]);
    arm();
    send(48'({CMD_MEM_WRITE, 16'h0010, 8'hA5}), 32);
    wait_idle();
    rd_mem(16'h0010, d);
    chk("guarded_write", 8'h5A, d[15:8]);
    @(posedge clk);
    #1 guard_n = 1'b0;
    arm();
    send(48'({CMD_STATUS_WRITE, 8'h00}), 16);
    rd_status(s);
    chk("hw_locked", 8'h8E, s);
    @(posedge clk);
    #1 guard_n = 1'b1;
    send(48'({CMD_STATUS_WRITE, 8'h00}), 16);
    wait_idle();
    rd_status(s);
    chk("unlocked_write", 8'h00, s);
    finish_test();
  end

  initial begin
    #800_000;
    miscompares++;
    finish_test();
  end
endmodule // spi_eeprom_command_status_test
`default_nettype wire
